// ---- hw/ipw_tick_gen.sv ----
/*
 * Prescaler giving one-cycle second and minute ticks from the clock.
 * Assumes restart_i pulses whenever the countdown is (re)loaded, so
 * the first unit after a load is always a full one.
 */
`timescale 1ns/1ps
`include "ipw_cfg.svh"

module ipw_tick_gen #(
    parameter int unsigned SEC_CYCLES  = `IPW_SEC_CYCLES,
    parameter int unsigned SEC_PER_MIN = `IPW_SEC_PER_MIN
) (
    input  wire logic mclk_i,
    input  wire logic rst_b_i,
    input  wire logic restart_i,
    output logic      sec_tick_o,
    output logic      min_tick_o
);
    import ipw_pkg::*;

    ipw_tick_t st;
    ipw_tick_t next_st;

    always_comb begin
        next_st = st;
        next_st.sec_tick = 1'b0;
        next_st.min_tick = 1'b0;
        if (restart_i) begin
            next_st.sec_cnt = 32'h0000_0000;
            next_st.min_cnt = 8'h00;
        end else if (st.sec_cnt >= SEC_CYCLES - 1) begin
            next_st.sec_cnt  = 32'h0000_0000;
            next_st.sec_tick = 1'b1;
            if (32'(st.min_cnt) >= SEC_PER_MIN - 1) begin
                next_st.min_cnt  = 8'h00;
                next_st.min_tick = 1'b1;
            end else begin
                next_st.min_cnt = st.min_cnt + 8'h01;
            end
        end else begin
            next_st.sec_cnt = st.sec_cnt + 32'h0000_0001;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sec_tick_o = st.sec_tick;
    assign min_tick_o = st.min_tick;

endmodule

// ---- hw/ipw_watchdog.sv ----
/*
 * Watchdog timer behind an index/data I/O port pair with key-based
 * configuration unlock, logical-device select and activity reload.
 * Assumes I/O cycles arrive as one-cycle strobes on mclk_i; mouse and
 * keyboard activity arrive asynchronously from pins.
 */
`timescale 1ns/1ps
`include "ipw_cfg.svh"

// How it works
// - Two back-to-back unlock key writes to index port open configuration.
// - Index port write picks a register; data port reads or writes it.
// - Logical device number eight routes indexed accesses to the watchdog.
// - Watchdog is disabled at reset; activation register bit zero enables.
// - Unit register bit 3: zero counts seconds, one counts minutes.
// - Count zero stops the timer; 1 to 255 units until timeout.
// - Every count register write restarts the countdown from that value.
// - Expiry before reload drives a timeout pulse out.
// - Control bit 7 lets mouse activity reload the count; resets off.
// - Control bit 6 lets keyboard activity reload the count; resets off.
// - Writing control bit 5 forces a timeout now; bit reads back zero.
// - Control bit 4 reads one once the watchdog has timed out.
// - A lock key write to the index port closes configuration.
module ipw_watchdog #(
    parameter int unsigned SEC_CYCLES  = `IPW_SEC_CYCLES,
    parameter int unsigned SEC_PER_MIN = `IPW_SEC_PER_MIN
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_b_i,
    input  wire logic [15:0] io_addr_i,
    input  wire logic        io_wr_i,
    input  wire logic        io_rd_i,
    input  wire logic [7:0]  io_wdata_i,
    input  wire logic        mouse_act_i,
    input  wire logic        kbd_act_i,
    output logic      [7:0]  io_rdata_o,
    output logic             wdt_timeout_o
);
    import ipw_pkg::*;

    ipw_state_t st;
    ipw_state_t next_st;
    logic       sec_tick;
    logic       min_tick;
    logic       restart;
    logic       idx_wr;
    logic       dat_wr;
    logic       dat_rd;
    logic       wdt_sel;
    logic       unit_tick;
    logic       ms_edge;
    logic       kb_edge;

    // Decoded port strobes
    assign idx_wr = io_wr_i && (io_addr_i == `IPW_INDEX_PORT);
    assign dat_wr = io_wr_i && (io_addr_i == `IPW_DATA_PORT)
                    && (st.lock == IPW_OPEN);
    assign dat_rd = io_rd_i && (io_addr_i == `IPW_DATA_PORT)
                    && (st.lock == IPW_OPEN);

    assign wdt_sel = (st.ldn == `IPW_LDN_WDT);

    assign ms_edge = st.ms_sync[1] && !st.ms_prev && st.mouse_en;
    assign kb_edge = st.kb_sync[1] && !st.kb_prev && st.kbd_en;

    assign unit_tick = st.unit_min ? min_tick : sec_tick;

    // Any fresh load restarts the prescaler so the first unit is whole
    assign restart = (dat_wr && wdt_sel && (st.idx == `IPW_REG_COUNT))
                     || ms_edge || kb_edge;

    ipw_tick_gen #(
        .SEC_CYCLES  (SEC_CYCLES),
        .SEC_PER_MIN (SEC_PER_MIN)
    ) u_tick (
        .mclk_i     (mclk_i),
        .rst_b_i    (rst_b_i),
        .restart_i  (restart),
        .sec_tick_o (sec_tick),
        .min_tick_o (min_tick)
    );

    always_comb begin
        next_st = st;
        next_st.timeout = 1'b0;

        // First stage feeds only the second
        next_st.ms_sync = {st.ms_sync[0], mouse_act_i};
        next_st.kb_sync = {st.kb_sync[0], kbd_act_i};
        next_st.ms_prev = st.ms_sync[1];
        next_st.kb_prev = st.kb_sync[1];

        // Index port: keys and register pointer
        if (idx_wr) begin
            case (st.lock)
                IPW_LOCKED: begin
                    if (io_wdata_i == `IPW_UNLOCK_KEY) begin
                        next_st.lock = IPW_HALF;
                    end
                end
                IPW_HALF: begin
                    if (io_wdata_i == `IPW_UNLOCK_KEY) begin
                        next_st.lock = IPW_OPEN;
                    end else begin
                        next_st.lock = IPW_LOCKED;
                    end
                end
                IPW_OPEN: begin
                    if (io_wdata_i == `IPW_LOCK_KEY) begin
                        next_st.lock = IPW_LOCKED;
                    end else begin
                        next_st.idx = io_wdata_i;
                    end
                end
                default: begin
                    next_st.lock = IPW_LOCKED;
                end
            endcase
        end

        if (ms_edge || kb_edge) begin
            next_st.cnt_cur = st.cnt_load;
            next_st.status  = 1'b0;
        end

        if (st.act && (st.cnt_cur != 8'h00) && unit_tick
            && !ms_edge && !kb_edge) begin
            next_st.cnt_cur = st.cnt_cur - 8'h01;
            if (st.cnt_cur == 8'h01) begin
                next_st.timeout = 1'b1;
                next_st.status  = 1'b1;
            end
        end

        if (dat_wr) begin
            if (st.idx == `IPW_REG_LDN) begin
                next_st.ldn = io_wdata_i;
            end else if (wdt_sel && (st.idx == `IPW_REG_ACTIVATE)) begin
                next_st.act = io_wdata_i[`IPW_ACT_BIT];
                // disable clears status
                // An expiry in this same cycle wins over the clear
                if (!io_wdata_i[`IPW_ACT_BIT]) begin
                    next_st.status = next_st.timeout;
                end
            end else if (wdt_sel && (st.idx == `IPW_REG_UNIT)) begin
                next_st.unit_min = io_wdata_i[`IPW_UNIT_BIT];
            end else if (wdt_sel && (st.idx == `IPW_REG_COUNT)) begin
                next_st.cnt_load = io_wdata_i;
                next_st.cnt_cur  = io_wdata_i;
                // reload clears status
                // Expiry in the write cycle still pulses, so status follows
                next_st.status   = next_st.timeout;
            end else if (wdt_sel && (st.idx == `IPW_REG_CTRL)) begin
                next_st.mouse_en = io_wdata_i[`IPW_MOUSE_BIT];
                next_st.kbd_en   = io_wdata_i[`IPW_KBD_BIT];
                if (io_wdata_i[`IPW_FORCE_BIT]) begin
                    next_st.timeout = 1'b1;
                    next_st.status  = 1'b1;
                end
            end
        end

        // Read data is held until the next read strobe on any port
        if (io_rd_i) begin
            next_st.rdata = `IPW_IDLE_RDATA;
            if (dat_rd) begin
                if (st.idx == `IPW_REG_LDN) begin
                    next_st.rdata = st.ldn;
                end else if (wdt_sel && (st.idx == `IPW_REG_ACTIVATE)) begin
                    next_st.rdata = {7'h00, st.act};
                end else if (wdt_sel && (st.idx == `IPW_REG_UNIT)) begin
                    next_st.rdata = {4'h0, st.unit_min, 3'h0};
                end else if (wdt_sel && (st.idx == `IPW_REG_COUNT)) begin
                    next_st.rdata = st.cnt_load;
                end else if (wdt_sel && (st.idx == `IPW_REG_CTRL)) begin
                    next_st.rdata = {st.mouse_en, st.kbd_en, 1'b0,
                                     st.status, 4'h0};
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st          <= '0;
            st.lock     <= IPW_LOCKED;
            st.ldn      <= `IPW_LDN_RST;
            st.cnt_load <= `IPW_COUNT_RST;
            st.cnt_cur  <= `IPW_COUNT_RST;
            st.rdata    <= `IPW_IDLE_RDATA;
        end else begin
            st <= next_st;
        end
    end

    // Both outputs are plain flops of the state record
    assign io_rdata_o    = st.rdata;
    assign wdt_timeout_o = st.timeout;

endmodule

// ---- pkg/ipw_cfg.svh ----
/*
 * Constants of the indexed-port watchdog: port addresses, key values,
 * register indexes, field positions, reset values and tick timing.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef IPW_CFG_SVH
`define IPW_CFG_SVH

// I/O port addresses of the index and data ports
`define IPW_INDEX_PORT      16'h002E
`define IPW_DATA_PORT       16'h002F

// Keys written to the index port
`define IPW_UNLOCK_KEY      8'h87
`define IPW_LOCK_KEY        8'hAA

// Register indexes
`define IPW_REG_LDN         8'h07
`define IPW_REG_ACTIVATE    8'h30
`define IPW_REG_UNIT        8'hF0
`define IPW_REG_COUNT       8'hF1
`define IPW_REG_CTRL        8'hF2

// Logical device number of the watchdog
`define IPW_LDN_WDT         8'h08

// Field positions
`define IPW_ACT_BIT         0
`define IPW_UNIT_BIT        3
`define IPW_MOUSE_BIT       7
`define IPW_KBD_BIT         6
`define IPW_FORCE_BIT       5
`define IPW_STATUS_BIT      4

// Reset values
`define IPW_LDN_RST         8'h00
`define IPW_COUNT_RST       8'h00
`define IPW_IDLE_RDATA      8'hFF

// Tick timing: one unit of seconds, sixty seconds to the minute
`define IPW_CLK_MHZ         200
`define IPW_SEC_UNIT_S      1
`define IPW_SEC_PER_MIN     60
`define IPW_SEC_CYCLES      (`IPW_SEC_UNIT_S * `IPW_CLK_MHZ * 1000000)

`endif

// ---- pkg/ipw_pkg.sv ----
/*
 * Types of the indexed-port watchdog: unlock state machine and the
 * packed state records of the top module and the tick generator.
 * Assumes ipw_cfg.svh is on the include path.
 */
package ipw_pkg;

    typedef enum logic [2:0] {
        IPW_LOCKED = 3'b001,
        IPW_HALF   = 3'b010,
        IPW_OPEN   = 3'b100
    } ipw_lock_t;

    typedef struct packed {
        ipw_lock_t   lock;
        logic [7:0]  idx;
        logic [7:0]  ldn;
        logic        act;
        logic        unit_min;
        logic [7:0]  cnt_load;
        logic [7:0]  cnt_cur;
        logic        mouse_en;
        logic        kbd_en;
        logic        status;
        logic        timeout;
        logic [7:0]  rdata;
        logic [1:0]  ms_sync;
        logic [1:0]  kb_sync;
        logic        ms_prev;
        logic        kb_prev;
    } ipw_state_t;

    typedef struct packed {
        logic [31:0] sec_cnt;
        logic [7:0]  min_cnt;
        logic        sec_tick;
        logic        min_tick;
    } ipw_tick_t;

endpackage

// ---- test/ipw_chk.sv ----
/* Port checker of ipw_watchdog, bound at the foot of this file.
   Assumes one-cycle host strobes and a second of at least 9 cycles. */
`timescale 1ns/1ps
module ipw_chk #(
    parameter int unsigned SEC_CYCLES = 10
) (
    input wire logic        mclk_i,
    input wire logic        rst_b_i,
    input wire logic [15:0] io_addr_i,
    input wire logic        io_wr_i,
    input wire logic        io_rd_i,
    input wire logic [7:0]  io_wdata_i,
    input wire logic [7:0]  io_rdata_o,
    input wire logic        wdt_timeout_o
);
    logic       half, open_q;
    logic [7:0] idx, ldn, cnt;
    wire        wr_ix = io_wr_i && io_addr_i == 16'h002E;
    wire        wr_dt = io_wr_i && io_addr_i == 16'h002F && open_q;
    wire        rd_dt = io_rd_i && io_addr_i == 16'h002F;
    wire        sel   = open_q && ldn == 8'h08;
    wire        frc   = wr_dt && sel && idx == 8'hF2 && io_wdata_i[5];
    logic       frc_q;
    // Shadow of unlock state, index, device select and loaded count
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            {half, open_q, idx, ldn, cnt} <= '0;
        end else if (wr_ix && !open_q) begin
            half   <= io_wdata_i == 8'h87 && !half;
            open_q <= io_wdata_i == 8'h87 && half;
        end else if (wr_ix) begin
            open_q <= io_wdata_i != 8'hAA;
            idx    <= (io_wdata_i == 8'hAA) ? idx : io_wdata_i;
        end else if (wr_dt && idx == 8'h07) begin
            ldn <= io_wdata_i;
        end else if (wr_dt && idx == 8'hF1 && sel) begin
            cnt <= io_wdata_i;
        end
    end
    // Forced pulses are legal right after a count write
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            frc_q <= 1'b0;
        end else begin
            frc_q <= frc;
        end
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_pulse;
        wdt_timeout_o ##1 !wdt_timeout_o;
    endsequence
    property p_other; io_rd_i && !rd_dt |=> io_rdata_o == 8'hFF; endproperty
    a_other: assert property (p_other) else $error("odd port read");
    property p_hold; !io_rd_i |=> $stable(io_rdata_o); endproperty
    a_hold: assert property (p_hold) else $error("read data moved");
    property p_lock; rd_dt && !open_q |=> io_rdata_o == 8'hFF; endproperty
    a_lock: assert property (p_lock) else $error("locked read");
    property p_ldn;
        rd_dt && open_q && !sel && idx != 8'h07 |=> io_rdata_o == 8'hFF;
    endproperty
    a_ldn: assert property (p_ldn) else $error("other device read");
    property p_cnt;
        rd_dt && sel && idx == 8'hF1 |=> io_rdata_o == cnt;
    endproperty
    a_cnt: assert property (p_cnt) else $error("count read back");
    property p_force;
        wr_dt && sel && idx == 8'hF2 && io_wdata_i[5] |=> s_pulse;
    endproperty
    a_force: assert property (p_force) else $error("no forced pulse");
    property p_pulse; wdt_timeout_o |=> !wdt_timeout_o; endproperty
    a_pulse: assert property (p_pulse) else $error("pulse repeated");
    property p_quiet;
        wr_dt && sel && idx == 8'hF1 && io_wdata_i != 8'h00
            && SEC_CYCLES > 8 |=> ##1 (!wdt_timeout_o || frc_q) [*8];
    endproperty
    a_quiet: assert property (p_quiet) else $error("early timeout");
endmodule

bind ipw_watchdog ipw_chk #(.SEC_CYCLES(SEC_CYCLES)) u_chk (
    .mclk_i, .rst_b_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i,
    .io_rdata_o, .wdt_timeout_o
);

// ---- test/ipw_host_model.sv ----
/* Host software model issuing I/O port cycles to the watchdog.
   Assumes the bench calls its tasks one at a time. */
`timescale 1ns/1ps
module ipw_host_model (
    input  wire logic        mclk_i,
    input  wire logic [7:0]  io_rdata_i,
    output logic      [15:0] io_addr_o,
    output logic             io_wr_o,
    output logic             io_rd_o,
    output logic      [7:0]  io_wdata_o
);
    int gap = 0;
    initial {io_addr_o, io_wr_o, io_rd_o, io_wdata_o} = '0;
    task automatic io(input bit w, input logic [15:0] a,
                      input logic [7:0] v, output logic [7:0] r);
        repeat (gap + 1) @(posedge mclk_i);
        io_addr_o <= a;
        io_wdata_o <= v;
        io_wr_o <= w;
        io_rd_o <= !w;
        @(posedge mclk_i);
        {io_wr_o, io_rd_o} <= 2'b00;
        // Released lines flip so a stale value never looks valid
        io_addr_o <= ~a;
        io_wdata_o <= ~v;
        if (!w) @(posedge mclk_i);
        r = io_rdata_i;
    endtask
    task automatic unlock();
        logic [7:0] r;
        io(1'b1, 16'h002E, 8'h87, r);
        io(1'b1, 16'h002E, 8'h87, r);
    endtask
    task automatic cfg(input logic [7:0] i, input logic [7:0] v);
        logic [7:0] r;
        io(1'b1, 16'h002E, i, r);
        io(1'b1, 16'h002F, v, r);
    endtask
endmodule

// ---- test/tb_top.sv ----
/* Self-checking bench of ipw_watchdog through the host model.
   Assumes a shortened prescaler: 10 cycles a second, 3 to a minute. */
`timescale 1ns/1ps
module tb_top;
    localparam int SC = 10;
    logic        mclk_i = 1'b0;
    logic        rst_b_i, io_wr_i, io_rd_i, mouse_act_i, kbd_act_i;
    logic        wdt_timeout_o;
    logic [15:0] io_addr_i;
    logic [7:0]  io_wdata_i, io_rdata_o, d;
    logic [7:0]  rv [4] = '{8'h30, 8'hF0, 8'hF1, 8'hF2};
    int          bad_count = 0;
    int          checks = 0;
    int          cyc = 0;
    ipw_watchdog #(.SEC_CYCLES(SC), .SEC_PER_MIN(3)) DUT (
        .mclk_i, .rst_b_i, .io_addr_i, .io_wr_i, .io_rd_i, .io_wdata_i,
        .mouse_act_i, .kbd_act_i, .io_rdata_o, .wdt_timeout_o
    );
    ipw_host_model host (
        .mclk_i, .io_rdata_i(io_rdata_o), .io_addr_o(io_addr_i),
        .io_wr_o(io_wr_i), .io_rd_o(io_rd_i), .io_wdata_o(io_wdata_i)
    );
    initial forever #2.5 mclk_i = ~mclk_i;
    task automatic rep(input string w, input logic [31:0] e, g, input bit ok);
        checks++;
        if (!ok) begin
            bad_count++;
            $display("wrong value %s expected %0h seen %0h", w, e, g);
        end
    endtask
    task automatic rc(input logic [7:0] i, input logic [7:0] e);
        host.io(1'b1, 16'h002E, i, d);
        host.io(1'b0, 16'h002F, 8'h00, d);
        rep("register", e, d, d === e);
    endtask
    task automatic to_wait(input int lo, input int hi, input int lim);
        int n;
        for (n = 1; n <= lim; n++) begin
            @(posedge mclk_i);
            if (wdt_timeout_o === 1'b1) break;
        end
        rep("timeout cycles", lo, n, n >= lo && n <= hi);
    endtask
    task automatic results();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Ceiling well above the few hundred cycles the tests need
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            results();
        end
    end
    initial begin
        {rst_b_i, mouse_act_i, kbd_act_i} = 3'b000;
        repeat (20) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        host.gap = 2;
        host.io(1'b1, 16'h002E, 8'h87, d);
        rc(8'h07, 8'hFF);
        host.io(1'b0, 16'h002E, 8'h00, d);
        rep("index port", 8'hFF, d, d === 8'hFF);
        host.unlock();
        rc(8'hF1, 8'hFF);
        rc(8'h07, 8'h00);
        host.cfg(8'h07, 8'h08);
        rc(8'h07, 8'h08);
        foreach (rv[k]) rc(rv[k], 8'h00);
        host.gap = 0;
        $display("test unlock done");
        host.cfg(8'h30, 8'h01);
        host.cfg(8'hF1, 8'h03);
        to_wait(3 * SC - 2, 3 * SC + 2, 40);
        rc(8'hF2, 8'h10);
        to_wait(61, 61, 60);
        rc(8'hF2, 8'h10);
        host.cfg(8'hF1, 8'h04);
        rc(8'hF2, 8'h00);
        repeat (20) @(posedge mclk_i);
        host.cfg(8'hF1, 8'h02);
        to_wait(2 * SC - 2, 2 * SC + 2, 40);
        $display("test seconds done");
        host.cfg(8'hF0, 8'h08);
        rc(8'hF0, 8'h08);
        host.cfg(8'hF1, 8'h02);
        to_wait(6 * SC - 2, 6 * SC + 2, 80);
        host.cfg(8'hF0, 8'h00);
        $display("test minutes done");
        for (int k = 0; k < 2; k++) begin
            host.cfg(8'hF2, k ? 8'h40 : 8'h80);
            host.cfg(8'hF1, 8'h03);
            repeat (20) @(posedge mclk_i);
            mouse_act_i <= k == 0;
            kbd_act_i <= k == 1;
            to_wait(3 * SC + 1, 3 * SC + 6, 40);
            {mouse_act_i, kbd_act_i} <= 2'b00;
        end
        $display("test activity done");
        host.cfg(8'hF2, 8'h00);
        host.cfg(8'hF1, 8'h00);
        host.cfg(8'hF2, 8'h20);
        to_wait(1, 2, 4);
        rc(8'hF2, 8'h10);
        to_wait(41, 41, 40);
        $display("test force done");
        host.cfg(8'h30, 8'h00);
        host.cfg(8'hF1, 8'h01);
        to_wait(41, 41, 40);
        host.io(1'b1, 16'h002E, 8'hAA, d);
        rc(8'hF1, 8'hFF);
        $display("test lock done");
        results();
    end
endmodule
